/* File: tco_load.sv */
/*
 * Load on the compare pins: a resistive pull-up that the design's
 * drivers override.
 * Assumes the output enable is active low and released pins float high.
 */
`timescale 1ns/1ps

module tco_load (
	// Design side of the pins
	input wire logic [tco_pkg::TCO_NCH-1:0] pin_drive,
	input wire logic [tco_pkg::TCO_NCH-1:0] pin_oe_n,
	// Level seen on the wire
	output logic [tco_pkg::TCO_NCH-1:0] pin_level
);
	import tco_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// A released pin goes to the pull-up level, never the last drive
	always_comb begin
		for (int i = 0; i < TCO_NCH; i++) begin
			pin_level[i] = pin_oe_n[i] ? 1'b1 : pin_drive[i];
		end
	end

endmodule : tco_load

/* File: tco_pkg.sv */
/*
 * Package for the timer compare output block: register offsets, control
 * field positions, reset values and the per-channel mode encoding.
 * Assumes a 32-bit APB register bus with byte addresses on paddr.
 */
package tco_pkg;

	////////////////////////////////////////////////////////////////////////
	// Sizes
	localparam int unsigned TCO_NCH = 4;
	localparam int unsigned TCO_TW = 16;
	localparam int unsigned TCO_AW = 8;

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets (compare register n sits at CC0 + 4*n)
	localparam logic [7:0] TCO_CTRL_OFS = 8'h00;
	localparam logic [7:0] TCO_COMPARE_CAPTURE_ENABLE_OFS = 8'h04;
	localparam logic [7:0] TCO_CC0_OFS = 8'h08;
	localparam logic [7:0] TCO_PORT_OFS = 8'h18;
	localparam logic [7:0] TCO_SHADOW_OFS = 8'h1c;
	localparam logic [7:0] TCO_STAT_OFS = 8'h20;
	localparam logic [7:0] TCO_TIMER_OFS = 8'h24;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int unsigned TCO_CTRL_CM_BIT = 0;
	localparam int unsigned TCO_CTRL_EDGE_BIT = 1;
	localparam int unsigned TCO_CTRL_RLD_BIT = 2;
	localparam int unsigned TCO_CTRL_W = 3;
	localparam int unsigned TCO_STAT_OVF_BIT = 0;

	////////////////////////////////////////////////////////////////////////
	// Reset values and limits
	localparam logic [2:0] TCO_CTRL_RST = 3'h0;
	localparam logic [7:0] TCO_COMPARE_CAPTURE_ENABLE_RST = 8'h00;
	localparam logic [15:0] TCO_CC_RST = 16'h0000;
	localparam logic [15:0] TCO_TIMER_RST = 16'h0000;
	localparam logic [15:0] TCO_TIMER_MAX = 16'hffff;
	localparam logic [3:0] TCO_PORT_RST = 4'hf;

	////////////////////////////////////////////////////////////////////////
	// Two-bit mode field of each channel in compare_capture_enable
	typedef enum logic [1:0] {
		TCO_MODE_OFF = 2'b00,
		TCO_MODE_CAP_PIN = 2'b01,
		TCO_MODE_CMP = 2'b10,
		TCO_MODE_CAP_WR = 2'b11
	} tco_mode_type;

endpackage : tco_pkg

/* File: tco_top.sv */
/*
 * Timer compare output block: 16-bit timer, four compare/capture
 * registers, port latches in compare mode 0 and 1, interrupt requests.
 * Assumes pclk is the machine clock and an APB master on the bus side;
 * the compare pins go to an external load and are read back as inputs.
 */
// The register offsets and register access over APB are this design's own decisions.
// Overview of operation
// - Each enabled register is compared with the count; a match drives pin, requests irq
// - One control bit picks compare mode 0 or 1 for all four registers
// - Pin takes its new level in the cycle the compare signal rises
// - Compare signal stays high while count equals the register
// - Register zero requests on compare rising or falling, per edge select bit
// - Registers one to three always request on compare going active
// - Enable register picks capture, compare or off for each register
// - Mode field: 00 off, 01 pin capture, 10 compare, 11 write capture
// - Overflow is rollover from all ones; it sets the overflow flag
// - Mode 0: output goes high on match
// - Mode 0: output goes low on timer overflow
// - Mode 0: port writes do not affect the output
// - Mode 0: latch driven only by compare and overflow, bus input cut
// - Mode 0: output keeps running each period without software
// - Mode 0: compare at all ones gives a one-cycle spike; compare at reload gives a one-cycle low
// - Timer steps once per machine clock
// - Mode 1: port writes reach the pin only at next match
// - Mode 1: shadow latch copied to output latch only on match
// - Mode 1: latches transparent while compare is active; a write updates both
// - Read-modify-write reads and writes the shadow latch
// - Plain port read returns the pin level
`timescale 1ns/1ps

module tco_top (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tco_pkg::TCO_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Compare pins, two-way
	input wire logic [tco_pkg::TCO_NCH-1:0] cmp_pin_in,
	output logic [tco_pkg::TCO_NCH-1:0] cmp_pin_out,
	output logic [tco_pkg::TCO_NCH-1:0] cmp_pin_oe_n,
	// Interrupt requests and timer events
	output logic [tco_pkg::TCO_NCH-1:0] cmp_irq_req,
	output logic timer_overflow
);
	import tco_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Mode field of one channel
	function automatic tco_mode_type ch_mode(input logic [7:0] compare_capture_enable,
		input int unsigned ch);
		return tco_mode_type'(compare_capture_enable[2*ch +: 2]);
	endfunction : ch_mode

	// Byte address of compare register n
	function automatic logic [7:0] cc_addr(input int unsigned ch);
		return 8'(TCO_CC0_OFS + 4 * ch);
	endfunction : cc_addr

	////////////////////////////////////////////////////////////////////////
	// State
	logic [TCO_CTRL_W-1:0] ctrl_q;
	logic [7:0] compare_capture_enable_q;
	logic [TCO_TW-1:0] cc_q [TCO_NCH];
	logic [TCO_TW-1:0] timer_q;
	logic [TCO_NCH-1:0] shadow_q;
	logic [TCO_NCH-1:0] shadow_d;
	logic [TCO_NCH-1:0] out_q;
	logic [TCO_NCH-1:0] cmp_q;
	logic [TCO_NCH-1:0] clr_pend_q;
	logic [TCO_NCH-1:0] irq_q;
	logic [TCO_NCH-1:0] cap_wr_q;
	logic [TCO_NCH-1:0] oe_n_q;
	logic [TCO_NCH-1:0] sync1_q;
	logic [TCO_NCH-1:0] sync2_q;
	logic [TCO_NCH-1:0] sync3_q;
	logic [TCO_NCH-1:0] pin_q;
	logic [TCO_NCH-1:0] pin_prev_q;
	logic ovf_flag_q;
	logic ovf_pulse_q;
	logic [31:0] prdata_q;
	logic pslverr_q;

	// Combinational terms
	logic [TCO_NCH-1:0] is_cmp;
	logic [TCO_NCH-1:0] match;
	logic [TCO_NCH-1:0] cc_wr;
	logic [TCO_NCH-1:0] pin_evt;
	logic mode0;
	logic ovf_now;
	logic setup;
	logic wr_en;
	logic port_wr;

	////////////////////////////////////////////////////////////////////////
	// Bus decode; the slave never stalls, so pready is tied high
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pwrite;
	assign port_wr = wr_en && paddr == TCO_PORT_OFS && pstrb[0];
	assign pready = 1'b1;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;

	// Compare match per channel, against the registered count
	assign mode0 = ~ctrl_q[TCO_CTRL_CM_BIT];
	assign ovf_now = timer_q == TCO_TIMER_MAX;
	always_comb begin
		for (int i = 0; i < TCO_NCH; i++) begin
			is_cmp[i] = ch_mode(compare_capture_enable_q, i) == TCO_MODE_CMP;
			match[i] = is_cmp[i] && timer_q == cc_q[i];
			cc_wr[i] = wr_en && paddr == cc_addr(i);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control, enable and status registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= TCO_CTRL_RST;
			compare_capture_enable_q <= TCO_COMPARE_CAPTURE_ENABLE_RST;
		end else if (wr_en && pstrb[0]) begin
			if (paddr == TCO_CTRL_OFS)
				ctrl_q <= pwdata[TCO_CTRL_W-1:0];
			if (paddr == TCO_COMPARE_CAPTURE_ENABLE_OFS)
				compare_capture_enable_q <= pwdata[7:0];
		end
	end

	// Overflow flag: a rollover in the clearing cycle still sets it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf_flag_q <= 1'b0;
			ovf_pulse_q <= 1'b0;
		end else begin
			ovf_pulse_q <= ovf_now;
			if (ovf_now)
				ovf_flag_q <= 1'b1;
			else if (wr_en && paddr == TCO_STAT_OFS && pstrb[0] &&
				pwdata[TCO_STAT_OVF_BIT])
				ovf_flag_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Timer: one step per machine clock, optional reload from register 0
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			timer_q <= TCO_TIMER_RST;
		else if (ovf_now)
			timer_q <= ctrl_q[TCO_CTRL_RLD_BIT] ? cc_q[0] : TCO_TIMER_RST;
		else
			timer_q <= timer_q + 16'h0001;
	end

	////////////////////////////////////////////////////////////////////////
	// Pin inputs: three stages, a change counts once stages two and three
	// agree, which filters a one-cycle glitch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= TCO_PORT_RST;
			sync2_q <= TCO_PORT_RST;
			sync3_q <= TCO_PORT_RST;
			pin_q <= TCO_PORT_RST;
			pin_prev_q <= TCO_PORT_RST;
		end else begin
			sync1_q <= cmp_pin_in;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			for (int i = 0; i < TCO_NCH; i++)
				if (sync2_q[i] == sync3_q[i])
					pin_q[i] <= sync3_q[i];
			pin_prev_q <= pin_q;
		end
	end

	// Capture events from the pins; register 0 honours the edge select
	always_comb begin
		for (int i = 0; i < TCO_NCH; i++) begin
			if (i == 0 && !ctrl_q[TCO_CTRL_EDGE_BIT])
				pin_evt[i] = ~pin_q[i] & pin_prev_q[i];
			else
				pin_evt[i] = pin_q[i] & ~pin_prev_q[i];
			pin_evt[i] = pin_evt[i] &&
				ch_mode(compare_capture_enable_q, i) == TCO_MODE_CAP_PIN;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Compare/capture registers; a low-byte write in write-capture mode
	// latches the count one cycle later and the written value is dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < TCO_NCH; i++)
				cc_q[i] <= TCO_CC_RST;
			cap_wr_q <= '0;
		end else begin
			for (int i = 0; i < TCO_NCH; i++) begin
				cap_wr_q[i] <= cc_wr[i] && pstrb[0] &&
					ch_mode(compare_capture_enable_q, i) == TCO_MODE_CAP_WR;
				if (cap_wr_q[i] || pin_evt[i])
					cc_q[i] <= timer_q;
				else if (cc_wr[i] &&
					ch_mode(compare_capture_enable_q, i) != TCO_MODE_CAP_WR) begin
					if (pstrb[0])
						cc_q[i][7:0] <= pwdata[7:0];
					if (pstrb[1])
						cc_q[i][15:8] <= pwdata[15:8];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shadow latch input: in mode 0 a compare channel ignores the bus
	always_comb begin
		for (int i = 0; i < TCO_NCH; i++) begin
			shadow_d[i] = shadow_q[i];
			if (port_wr && !(mode0 && is_cmp[i]))
				shadow_d[i] = pwdata[i];
		end
	end

	// Output latches. Mode 0 sets on match and clears on overflow; when
	// both fall in one cycle (compare at all ones) the clear is deferred
	// a cycle, so the pulse shrinks to one clock instead of vanishing.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shadow_q <= TCO_PORT_RST;
			out_q <= TCO_PORT_RST;
			clr_pend_q <= '0;
		end else begin
			shadow_q <= shadow_d;
			for (int i = 0; i < TCO_NCH; i++) begin
				clr_pend_q[i] <= mode0 && match[i] && ovf_now;
				if (!is_cmp[i])
					out_q[i] <= shadow_d[i];
				else if (mode0) begin
					if (match[i])
						out_q[i] <= 1'b1;
					else if (ovf_now || clr_pend_q[i])
						out_q[i] <= 1'b0;
				end else if (match[i])
					out_q[i] <= shadow_d[i];
			end
		end
	end

	// Pin drive: released in capture modes so the pin can be an input
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			oe_n_q <= '0;
		else
			for (int i = 0; i < TCO_NCH; i++)
				oe_n_q[i] <= ch_mode(compare_capture_enable_q, i) == TCO_MODE_CAP_PIN ||
					ch_mode(compare_capture_enable_q, i) == TCO_MODE_CAP_WR;
	end
	assign cmp_pin_out = out_q;
	assign cmp_pin_oe_n = oe_n_q;

	////////////////////////////////////////////////////////////////////////
	// Compare signal and interrupt requests; both rise on the same edge, except register 0's request on falling edge select
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_q <= '0;
			irq_q <= '0;
		end else begin
			cmp_q <= match;
			for (int i = 0; i < TCO_NCH; i++) begin
				if (i == 0 && !ctrl_q[TCO_CTRL_EDGE_BIT])
					irq_q[i] <= cmp_q[i] & ~match[i];
				else
					irq_q[i] <= match[i] & ~cmp_q[i];
			end
		end
	end
	assign cmp_irq_req = irq_q;
	assign timer_overflow = ovf_pulse_q;

	////////////////////////////////////////////////////////////////////////
	// Read data and error, registered in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
			pslverr_q <= 1'b0;
		end else if (setup) begin
			prdata_q <= '0;
			pslverr_q <= 1'b0;
			case (paddr)
				TCO_CTRL_OFS: prdata_q[TCO_CTRL_W-1:0] <= ctrl_q;
				TCO_COMPARE_CAPTURE_ENABLE_OFS: prdata_q[7:0] <= compare_capture_enable_q;
				cc_addr(0): prdata_q[15:0] <= cc_q[0];
				cc_addr(1): prdata_q[15:0] <= cc_q[1];
				cc_addr(2): prdata_q[15:0] <= cc_q[2];
				cc_addr(3): prdata_q[15:0] <= cc_q[3];
				TCO_PORT_OFS: prdata_q[TCO_NCH-1:0] <= pin_q;
				TCO_SHADOW_OFS: prdata_q[TCO_NCH-1:0] <= shadow_q;
				TCO_STAT_OFS: prdata_q[TCO_STAT_OVF_BIT] <= ovf_flag_q;
				TCO_TIMER_OFS: prdata_q[15:0] <= timer_q;
				default: pslverr_q <= 1'b1;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking tco_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_cmp_level_hold: assert property (
		is_cmp[1] && timer_q == cc_q[1] |=> cmp_q[1])
		else $error("compare signal not active on equal count");

	a_enable_decode: assert property (
		ch_mode(compare_capture_enable_q, 2) != TCO_MODE_CMP && $stable(compare_capture_enable_q) |=> !cmp_q[2])
		else $error("compare signal active on non-compare channel");

	a_pin_same_cycle: assert property (
		mode0 && $stable(ctrl_q) && is_cmp[1] && $rose(cmp_q[1])
		|-> out_q[1] && irq_q[1])
		else $error("pin or request late for compare edge");

	a_crc_fall_irq: assert property (
		!ctrl_q[TCO_CTRL_EDGE_BIT] && $stable(ctrl_q) && $fell(cmp_q[0])
		|-> irq_q[0])
		else $error("falling compare request missing");

	a_cc3_rise_irq: assert property (
		$rose(cmp_q[3]) |-> irq_q[3])
		else $error("compare request missing on rising edge");

	a_overflow_flag: assert property (
		ovf_now |=> ovf_flag_q && timer_overflow)
		else $error("overflow not flagged");

	a_timer_step: assert property (
		!ovf_now |=> timer_q == $past(timer_q) + 16'h0001)
		else $error("timer did not step by one");

	a_mode0_set: assert property (
		mode0 && match[2] |=> out_q[2])
		else $error("mode 0 output not set on match");

	a_mode0_clear: assert property (
		mode0 && is_cmp[2] && ovf_now && !match[2] |=> !out_q[2])
		else $error("mode 0 output not cleared on overflow");

	a_mode0_no_write: assert property (
		mode0 && is_cmp[0] && port_wr && !match[0] && !ovf_now &&
		!clr_pend_q[0] |=> $stable(out_q[0]) && $stable(shadow_q[0]))
		else $error("mode 0 latch changed by a port write");

	a_mode0_spike: assert property (
		mode0 && is_cmp[1] && cc_q[1] == TCO_TIMER_MAX && ovf_now &&
		!cc_wr[1] |=> out_q[1] ##1 !out_q[1])
		else $error("all-ones compare did not give a one-cycle spike");

	a_mode1_hold: assert property (
		!mode0 && is_cmp[0] && !match[0] && $stable(ctrl_q)
		|=> $stable(out_q[0]))
		else $error("mode 1 output changed without a match");

	a_mode1_copy: assert property (
		!mode0 && match[3] |=> out_q[3] == shadow_q[3])
		else $error("mode 1 shadow not copied on match");

	a_mode1_transp: assert property (
		!mode0 && match[2] && port_wr |=> out_q[2] == $past(pwdata[2]))
		else $error("port write during compare missed the pin");

	a_port_read_pin: assert property (
		setup && paddr == TCO_PORT_OFS
		|=> prdata_q[TCO_NCH-1:0] == $past(pin_q))
		else $error("port read did not return the pin level");

endmodule : tco_top

/* File: tco_top_bench.sv */
/*
 * Self-checking bench for the timer compare output block: APB tasks,
 * PWM period measurement in mode 0, shadow latch sequence in mode 1.
 * Assumes zero wait states are not relied on and reload from register 0.
 */
`timescale 1ns/1ps

module tco_top_bench;
	import tco_pkg::*;

	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ovf, err;
	logic [TCO_AW-1:0] paddr;
	logic [31:0] pwdata, prdata, rd, t1;
	logic [3:0] pstrb;
	logic [TCO_NCH-1:0] pin_in, pin_out, pin_oe_n, irq;
	int n_errors = 0;
	int comparisons = 0;
	// Reload value, then three match points inside the 256-cycle period
	logic [15:0] cc_tab [4] = '{16'hff00, 16'hff10, 16'hffff, 16'hff80};

	tco_top tco_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cmp_pin_in(pin_in), .cmp_pin_out(pin_out),
		.cmp_pin_oe_n(pin_oe_n), .cmp_irq_req(irq), .timer_overflow(ovf));
	tco_load tco_load_i (.pin_drive(pin_out), .pin_oe_n(pin_oe_n),
		.pin_level(pin_in));

	////////////////////////////////////////////////////////////////////////
	// Clock and watchdog; the first rollover alone takes 65536 cycles
	initial begin
		pclk = 0;
		forever #12.5 pclk = ~pclk;
	end
	initial begin
		#2500000;
		n_errors++;
		final_report;
	end

	////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task final_report;
		if (n_errors == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : final_report

	task check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// One APB transfer, held until pready is seen at a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'hf;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		#1;
	endtask : apb

	task wait_ovf;
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while (ovf !== 1'b1 && n < 70000);
	endtask : wait_ovf

	// Counts high samples and request pulses over one full period
	task automatic measure(input logic edge_up);
		int hi [4] = '{0, 0, 0, 0};
		int fi [4] = '{0, 0, 0, 0};
		int ni [4] = '{0, 0, 0, 0};
		wait_ovf;
		for (int k = 1; k <= 256; k++) begin
			@(posedge pclk);
			#1;
			for (int c = 0; c < 4; c++) begin
				if (pin_out[c] === 1'b1) hi[c]++;
				if (irq[c] === 1'b1) begin
					ni[c]++;
					if (fi[c] == 0) fi[c] = k;
				end
			end
		end
		check("ovf", ovf, 1);
		for (int c = 0; c < 4; c++) begin
			check("high", cc_tab[c] == 16'hffff ? 1 : 16'hffff - cc_tab[c],
				hi[c]);
			check("irq_at", fi[c], c == 0 ? (edge_up ? 1 : 2) :
				cc_tab[c] - 16'hff00 + 1);
			check("irq_n", ni[c], 1);
		end
	endtask : measure

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		pstrb = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1;
		apb(0, TCO_CTRL_OFS, 0);
		check("ctrl", rd, 0);
		apb(0, TCO_COMPARE_CAPTURE_ENABLE_OFS, 0);
		check("compare_capture_enable", rd, 0);
		apb(0, 8'h40, 0);
		check("unmapped", {rd[30:0], err}, 1);
		apb(0, TCO_PORT_OFS, 0);
		check("port", rd, 32'hf);
		apb(0, TCO_TIMER_OFS, 0);
		t1 = rd;
		apb(0, TCO_TIMER_OFS, 0);
		check("tick", rd - t1, 3);
		for (int i = 0; i < 4; i++) begin
			apb(1, 8'(TCO_CC0_OFS + 4 * i), {16'h0, cc_tab[i]});
		end
		apb(1, TCO_COMPARE_CAPTURE_ENABLE_OFS, 32'haa);
		// Reload on, request on rising edge, mode 0
		apb(1, TCO_CTRL_OFS, 32'h6);
		fork
			measure(1);
			begin
				repeat (40) @(posedge pclk);
				apb(1, TCO_PORT_OFS, 0);
			end
		join
		apb(0, TCO_STAT_OFS, 0);
		check("flag", rd, 1);
		apb(1, TCO_STAT_OFS, 1);
		apb(0, TCO_STAT_OFS, 0);
		check("flag", rd, 0);
		apb(1, TCO_CTRL_OFS, 32'h4);
		measure(0);
		// Mode 1; register three matches as the port write lands
		apb(1, TCO_CTRL_OFS, 32'h5);
		apb(1, 8'(TCO_CC0_OFS + 8'h0c), 32'hff02);
		apb(1, TCO_PORT_OFS, 0);
		wait_ovf;
		wait_ovf;
		check("pins", pin_out, 4'h0);
		apb(1, TCO_PORT_OFS, 32'hf);
		check("pins", pin_out, 4'h8);
		apb(0, TCO_SHADOW_OFS, 0);
		check("shadow", rd, 32'hf);
		repeat (14) @(posedge pclk);
		#1;
		check("pins", pin_out, 4'ha);
		repeat (6) @(posedge pclk);
		apb(0, TCO_PORT_OFS, 0);
		check("port", rd, 32'ha);
		// Every mode code: drive in off and compare, release in capture
		for (int m = 0; m < 4; m++) begin
			apb(1, TCO_COMPARE_CAPTURE_ENABLE_OFS, {24'h0, {4{2'(m)}}});
			@(posedge pclk);
			#1;
			check("oe_n", pin_oe_n, m[0] ? 4'hf : 4'h0);
		end
		final_report;
	end

endmodule : tco_top_bench
